// ---- pkg/scfh_pkg.sv ----
// Package of constants and types for the serial command frame handler.
`default_nettype none

package scfh_pkg;

   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned FIFO_DEPTH = 8;

   // Frame lengths in bytes and the position of the command code inside a frame.
   localparam logic [3:0] SER_LEN    = 4'h9;
   localparam logic [3:0] CAN_LEN    = 4'h7;
   localparam logic [3:0] SER_BODY   = 4'h1;
   localparam logic [3:0] CAN_BODY   = 4'h0;
   localparam logic [3:0] ADDR_POS   = 4'h0;
   localparam logic [3:0] IDX_RST    = 4'h0;

   // Reply status codes.
   localparam logic [7:0] ST_OK        = 8'h64;
   localparam logic [7:0] ST_STORED    = 8'h65;
   localparam logic [7:0] ST_BAD_SUM   = 8'h01;
   localparam logic [7:0] ST_BAD_CMD   = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE = 8'h04;
   localparam logic [7:0] ST_LOCKED    = 8'h05;
   localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

   typedef enum logic [1:0] {
      SCFH_RX   = 2'b00,
      SCFH_EXEC = 2'b01,
      SCFH_TX   = 2'b10
   } scfh_phase_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  kind;
      logic [7:0]  bank;
      logic [31:0] value;
   } scfh_cmd_t;

   typedef struct packed {
      logic [7:0]  status;
      logic [31:0] value;
   } scfh_result_t;

endpackage : scfh_pkg

`default_nettype wire

// ---- hdl/scfh_top.sv ----
// Serial command frame handler: receive FIFO, frame parser, executor handshake and reply sender.
//
// Contract
// - Transmit only a reply to a command just received, never spontaneously.
// - Keep the line driver off except while a reply is being sent.
// - Every accepted command frame yields exactly one reply frame.
// - Command execution completes before the first reply byte is offered.
// - Command core is opcode, type, motor or bank, and four value bytes.
// - Serial command: address, opcode, type, bank, value MSB first, checksum.
// - Command checksum is the 8-bit sum of the eight preceding bytes.
// - Serial reply: reply address, module address, status, opcode, value, checksum.
// - Reply checksum is the 8-bit sum of all other reply bytes.
// - Status 100 means executed, 101 means stored into program memory.
// - Error statuses: 1 checksum, 2 command, 3 type, 4 value, 5 locked, 6 unavailable.
// - CAN variant frames carry neither address byte nor checksum byte; the CAN reply here still starts with the module address byte.
`default_nettype none

module scfh_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 8
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         ce,
   // Filling side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Draining side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   localparam int unsigned AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                in_rdy;
   } scfh_fifo_st_t;

   localparam scfh_fifo_st_t FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1};
   localparam logic [AW:0]   FULL_CNT = (AW + 1)'(D);

   scfh_fifo_st_t s;
   scfh_fifo_st_t n;
   logic          push;
   logic          pop;

   assign in_ready  = s.in_rdy;
   assign out_valid = (s.cnt != '0);
   assign out_data  = s.mem[s.rp];

   // Pointers wrap by overflow, so the depth must be a power of two.
   always_comb begin
      n    = s;
      push = in_valid & s.in_rdy;
      pop  = out_ready & (s.cnt != '0);
      if (push) begin
         n.mem[s.wp] = in_data;
         n.wp        = s.wp + 1'b1;
      end
      if (pop) begin
         n.rp = s.rp + 1'b1;
      end
      unique case ({push, pop})
         2'b10:   n.cnt = s.cnt + 1'b1;
         2'b01:   n.cnt = s.cnt - 1'b1;
         default: n.cnt = s.cnt;
      endcase
      n.in_rdy = (n.cnt != FULL_CNT);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= FIFO_RST;
      end else if (ce) begin
         s <= n;
      end
   end

endmodule : scfh_fifo

module scfh_top (
   // Clock, reset and clock enable
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // Configuration
   input  wire logic [7:0]            my_addr,
   input  wire logic [7:0]            host_addr,
   input  wire logic                  can_mode,
   // Received bytes from the line receiver
   input  wire logic                  rx_valid,
   input  wire logic [7:0]            rx_data,
   output logic                       rx_ready,
   // Command executor
   output logic                       exec_valid,
   output scfh_pkg::scfh_cmd_t        exec_cmd,
   input  wire logic                  exec_done,
   input  wire scfh_pkg::scfh_result_t exec_result,
   // Reply bytes to the line transmitter
   output logic                       tx_valid,
   output logic [7:0]                 tx_data,
   input  wire logic                  tx_ready,
   input  wire logic                  tx_busy,
   output logic                       drv_en
);

   typedef struct packed {
      scfh_pkg::scfh_phase_t phase;
      logic [3:0]            idx;
      logic [7:0]            sum;
      logic [8:0][7:0]       fb;
      logic [3:0]            len;
      logic                  exec_valid;
      scfh_pkg::scfh_cmd_t   cmd;
      logic                  tx_valid;
      logic [7:0]            tx_data;
      logic                  drv_en;
   } scfh_top_st_t;

   scfh_top_st_t s;
   scfh_top_st_t n;

   logic       f_valid;
   logic [7:0] f_data;
   logic       f_pop;

   // The parser only drains while idle, so a host that talks over a reply fills the FIFO and sees rx_ready fall.
   scfh_fifo #(
      .W (scfh_pkg::BYTE_W),
      .D (scfh_pkg::FIFO_DEPTH)
   ) scfh_fifo_i (
      .clock     (clock),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (rx_valid),
      .in_data   (rx_data),
      .in_ready  (rx_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_pop)
   );

   assign exec_valid = s.exec_valid;
   assign exec_cmd   = s.cmd;
   assign tx_valid   = s.tx_valid;
   assign tx_data    = s.tx_data;
   assign drv_en     = s.drv_en;

   logic [3:0]          flen;
   logic [3:0]          body;
   logic                rs_go;
   logic [7:0]          rs_status;
   logic [31:0]         rs_value;
   logic [7:0]          rs_opcode;
   logic [7:0]          chk;
   scfh_pkg::scfh_cmd_t c;

   always_comb begin
      n           = s;
      n.exec_valid = 1'b0;
      f_pop       = 1'b0;
      rs_go       = 1'b0;
      rs_status   = scfh_pkg::ST_OK;
      rs_value    = '0;
      rs_opcode   = s.cmd.opcode;
      chk         = 8'h00;
      flen        = can_mode ? scfh_pkg::CAN_LEN : scfh_pkg::SER_LEN;
      body        = can_mode ? scfh_pkg::CAN_BODY : scfh_pkg::SER_BODY;
      c           = '0;

      unique case (s.phase)
         scfh_pkg::SCFH_RX: begin
            f_pop = f_valid;
            if (f_valid) begin
               n.fb[s.idx] = f_data;
               n.sum       = s.sum + f_data;
               n.idx       = s.idx + 4'h1;
               if (s.idx == flen - 4'h1) begin
                  n.idx = scfh_pkg::IDX_RST;
                  n.sum = 8'h00;
                  // Bytes land in order, so fixed offsets from the command position decode the core.
                  c.opcode = n.fb[body];
                  c.kind   = n.fb[body + 4'h1];
                  c.bank   = n.fb[body + 4'h2];
                  c.value  = {n.fb[body + 4'h3], n.fb[body + 4'h4], n.fb[body + 4'h5], n.fb[body + 4'h6]};
                  if (!can_mode && n.fb[scfh_pkg::ADDR_POS] != my_addr) begin
                     n.phase = scfh_pkg::SCFH_RX;
                  end else if (!can_mode && s.sum != f_data) begin
                     rs_go     = 1'b1;
                     rs_status = scfh_pkg::ST_BAD_SUM;
                     rs_opcode = c.opcode;
                  end else begin
                     n.cmd        = c;
                     n.exec_valid = 1'b1;
                     n.phase      = scfh_pkg::SCFH_EXEC;
                  end
               end
            end
         end
         scfh_pkg::SCFH_EXEC: begin
            // The reply waits for the executor, whatever it has to do.
            if (exec_done) begin
               rs_go     = 1'b1;
               rs_status = exec_result.status;
               rs_value  = exec_result.value;
            end
         end
         scfh_pkg::SCFH_TX: begin
            if (s.tx_valid && tx_ready) begin
               n.idx = s.idx + 4'h1;
               if (s.idx + 4'h1 < s.len) begin
                  n.tx_data = s.fb[s.idx + 4'h1];
               end else begin
                  n.tx_valid = 1'b0;
               end
            end else if (!s.tx_valid && !tx_busy) begin
               // Releasing the driver only after the transmitter is idle keeps the stop bit on the line.
               n.drv_en = 1'b0;
               n.idx    = scfh_pkg::IDX_RST;
               n.phase  = scfh_pkg::SCFH_RX;
            end
         end
         default: begin
            n = '0;
         end
      endcase

      // The only way into transmission is through a received command.
      if (rs_go) begin
         n.fb = '0;
         if (can_mode) begin
            n.fb[0] = my_addr;
            n.fb[1] = rs_status;
            n.fb[2] = rs_opcode;
            n.fb[3] = rs_value[31:24];
            n.fb[4] = rs_value[23:16];
            n.fb[5] = rs_value[15:8];
            n.fb[6] = rs_value[7:0];
            n.len   = scfh_pkg::CAN_LEN;
         end else begin
            n.fb[0] = host_addr;
            n.fb[1] = my_addr;
            n.fb[2] = rs_status;
            n.fb[3] = rs_opcode;
            n.fb[4] = rs_value[31:24];
            n.fb[5] = rs_value[23:16];
            n.fb[6] = rs_value[15:8];
            n.fb[7] = rs_value[7:0];
            for (int i = 0; i < 8; i++) begin
               chk = chk + n.fb[i];
            end
            n.fb[8] = chk;
            n.len   = scfh_pkg::SER_LEN;
         end
         n.idx      = scfh_pkg::IDX_RST;
         n.phase    = scfh_pkg::SCFH_TX;
         n.drv_en   = 1'b1;
         n.tx_valid = 1'b1;
         n.tx_data  = n.fb[0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

endmodule : scfh_top

`default_nettype wire

// ---- testbench/scfh_top_assertions.sv ----
// Port-level assertions for the serial command frame handler.
`default_nettype none

module scfh_checker (
   // Clock and reset
   input wire logic                clock,
   input wire logic                rst,
   input wire logic                ce,
   input wire logic                can_mode,
   // Executor and reply side
   input wire logic                exec_valid,
   input wire scfh_pkg::scfh_cmd_t exec_cmd,
   input wire logic                tx_valid,
   input wire logic [7:0]          tx_data,
   input wire logic                tx_ready,
   input wire logic                tx_busy,
   input wire logic                drv_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [3:0] cnt_r;
   // Counts reply bytes accepted while the driver is on; clears when it drops.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= 4'h0;
      end else if (!drv_en) begin
         cnt_r <= 4'h0;
      end else if (ce && tx_valid && tx_ready) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   a_tx_needs_drv: assert property (tx_valid |-> drv_en) else $error("byte offered with driver off");
   a_drv_start: assert property ($rose(drv_en) |-> tx_valid) else $error("driver on without reply");
   a_exec_single: assert property (exec_valid |=> !exec_valid) else $error("command issued twice");
   a_exec_quiet: assert property (exec_valid |-> !drv_en && !tx_valid) else $error("reply before execution");
   a_cmd_stable: assert property ($changed(exec_cmd) |-> exec_valid) else $error("command changed alone");
   a_tx_hold: assert property (ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte not held");
   a_drv_drop: assert property (ce && drv_en && !tx_valid && !tx_busy |=> !drv_en)
      else $error("driver held after reply");
   a_reply_len: assert property ($fell(drv_en) |-> cnt_r == (can_mode ? 4'h7 : 4'h9))
      else $error("reply length wrong");
endmodule : scfh_checker

bind scfh_top scfh_checker scfh_checker_i (.clock(clock), .rst(rst), .ce(ce), .can_mode(can_mode),
   .exec_valid(exec_valid), .exec_cmd(exec_cmd), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_ready(tx_ready), .tx_busy(tx_busy), .drv_en(drv_en));

`default_nettype wire

// ---- testbench/scfh_line.sv ----
// Host-side line model: accepts reply bytes and stays busy while shifting them.
`default_nettype none

module scfh_line (
   // Clock, reset and pacing
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       slow,
   // Reply bytes
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   output logic           tx_ready,
   output logic           tx_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got[$];
   logic [1:0] sh;
   // A slow line drops tx_ready every other cycle, so the sender must hold its offer.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sh <= 2'h0;
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= !slow || !tx_ready;
         if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            sh <= 2'h2;
         end else if (sh != 2'h0) begin
            sh <= sh - 2'h1;
         end
      end
   end
   assign tx_busy = sh != 2'h0;
endmodule : scfh_line

`default_nettype wire

// ---- testbench/scfh_top_tb.sv ----
// Self-checking testbench for the serial command frame handler.
`default_nettype none

module scfh_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst = 1, ce = 1, can_mode = 0, slow = 0, rx_valid = 0, exec_done = 0;
   logic [7:0] my_addr = 8'h2a, host_addr = 8'h02, rx_data = 8'h00, tx_data;
   logic rx_ready, exec_valid, tx_valid, tx_ready, tx_busy, drv_en;
   scfh_pkg::scfh_result_t exec_result = '0;
   scfh_pkg::scfh_cmd_t exec_cmd, c;
   int fail_count = 0, compares = 0, n_exec = 0, n_full = 0;
   logic [7:0] b[9];
   always #25 clock = ~clock;
   always @(posedge clock) begin
      n_exec += (exec_valid === 1'b1);
      n_full += (rx_ready === 1'b0 && !rst);
   end
   scfh_top scfh_top_i (.clock(clock), .rst(rst), .ce(ce), .my_addr(my_addr), .host_addr(host_addr),
      .can_mode(can_mode), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_done(exec_done), .exec_result(exec_result),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_busy(tx_busy), .drv_en(drv_en));
   scfh_line scfh_line_i (.clock(clock), .rst(rst), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .tx_busy(tx_busy));
   task end_sim;
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   task chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         $display("wrong value at %0t: %s", $time, m);
         fail_count++;
      end
   endtask : chk
   task lim(input int n);
      if (n >= 400) begin
         chk(1'b0, "wait limit reached");
         end_sim;
      end
   endtask : lim
   task put(input logic [7:0] d);
      int n;
      rx_valid <= 1'b1;
      rx_data <= d;
      for (n = 0; n < 400; n++) begin
         @(negedge clock);
         if (rx_ready === 1'b1) break;
      end
      @(posedge clock);
      lim(n);
   endtask : put
   task send(input logic [7:0] a, input logic bad);
      int i;
      b[0] = a;
      {b[1], b[2], b[3], b[4], b[5], b[6], b[7]} = c;
      b[8] = {7'h00, bad};
      for (i = 0; i < 8; i++) b[8] += b[i];
      for (i = can_mode; i < 9 - can_mode; i++) put(b[i]);
      rx_valid <= 1'b0;
      // One idle edge keeps a following frame from raising valid in the same time step.
      @(posedge clock);
   endtask : send
   task serve(input logic [7:0] st, input int dly);
      int n;
      for (n = 0; n < 400 && exec_valid !== 1'b1; n++) @(negedge clock);
      lim(n);
      chk(exec_cmd === c, "command fields");
      repeat (dly) @(posedge clock);
      exec_done <= 1'b1;
      exec_result <= {st, ~c.value};
      @(posedge clock);
      exec_done <= 1'b0;
   endtask : serve
   task reply(input logic [7:0] st, input logic [31:0] v);
      logic [7:0] e[$];
      int n;
      e = {host_addr, my_addr, st, c.opcode, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
      foreach (e[i]) if (i < 8) e[8] += e[i];
      if (can_mode) e = e[1:7];
      for (n = 0; n < 400 && (drv_en !== 1'b0 || scfh_line_i.got.size() < e.size()); n++) @(negedge clock);
      lim(n);
      chk(scfh_line_i.got.size() == e.size(), "reply length");
      foreach (e[i]) chk(scfh_line_i.got[i] === e[i], "reply byte");
      scfh_line_i.got.delete();
      @(posedge clock);
   endtask : reply
   task t_codes;
      logic [7:0] st[8] = '{8'h64, 8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h64};
      foreach (st[i]) begin
         c = {8'h05, 8'(i), 8'h01, 32'h8123_45f0 + i};
         send(my_addr, 1'b0);
         serve(st[i], i + 1);
         reply(st[i], ~c.value);
      end
      chk(n_exec == 8, "one command per frame");
      $display("status code test done");
   endtask : t_codes
   task t_badsum;
      send(my_addr, 1'b1);
      reply(scfh_pkg::ST_BAD_SUM, 32'h0);
      chk(n_exec == 8, "bad frame executed");
      $display("bad checksum test done");
   endtask : t_badsum
   task t_foreign;
      send(my_addr + 8'h01, 1'b0);
      repeat (60) @(posedge clock);
      chk(n_exec == 8 && scfh_line_i.got.size() == 0 && drv_en === 1'b0, "foreign frame answered");
      $display("foreign address test done");
   endtask : t_foreign
   task t_can;
      can_mode <= 1'b1;
      @(posedge clock);
      send(my_addr, 1'b0);
      serve(scfh_pkg::ST_OK, 2);
      reply(scfh_pkg::ST_OK, ~c.value);
      can_mode <= 1'b0;
      @(posedge clock);
      $display("short framing test done");
   endtask : t_can
   task t_fill;
      slow <= 1'b1;
      send(my_addr, 1'b0);
      // The second frame breaks the host's wait on purpose to fill the buffer.
      fork
         send(my_addr, 1'b0);
         begin
            serve(scfh_pkg::ST_OK, 30);
            reply(scfh_pkg::ST_OK, ~c.value);
         end
      join
      serve(scfh_pkg::ST_STORED, 1);
      reply(scfh_pkg::ST_STORED, ~c.value);
      chk(n_full > 0, "buffer never refused");
      slow <= 1'b0;
      $display("buffer fill test done");
   endtask : t_fill
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(rx_ready === 1'b1 && drv_en === 1'b0 && tx_valid === 1'b0 && exec_valid === 1'b0, "reset state");
      t_codes;
      t_badsum;
      t_foreign;
      t_can;
      t_fill;
      end_sim;
   end
endmodule : scfh_top_tb

`default_nettype wire
